// ---- rtl/tsp_pkg.sv ----
package tsp_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] TSP_OFF_COUNT  = 8'h00;
  localparam logic [7:0] TSP_OFF_CONFIG = 8'h04;
  localparam logic [7:0] TSP_OFF_STATUS = 8'h08;
  localparam logic [7:0] TSP_OFF_MASK   = 8'h0c;
  localparam logic [7:0] TSP_OFF_CTRL   = 8'h10;

  // config field positions
  localparam int TSP_CFG_CSS_BIT  = 5;
  localparam int TSP_CFG_SES_BIT  = 4;
  localparam int TSP_CFG_PSA_BIT  = 3;
  localparam int TSP_CFG_RATE_LSB = 0;
  localparam int TSP_RATE_W       = 3;

  // status, mask and control field positions
  localparam int TSP_STS_OVF_BIT  = 0;
  localparam int TSP_MSK_OVF_BIT  = 0;
  localparam int TSP_CTL_SLP_BIT  = 0;
  localparam int TSP_CTL_CLRW_BIT = 1;

  // reset values
  localparam logic [5:0] TSP_CONFIG_RST = 6'h3f;
  localparam logic [7:0] TSP_COUNT_RST  = 8'h00;
  localparam logic       TSP_FLAG_RST   = 1'b0;
  localparam logic       TSP_MASK_RST   = 1'b0;
  localparam logic       TSP_SLEEP_RST  = 1'b0;

  // increments held off after a count write
  localparam logic [1:0] TSP_INHIBIT_CYCLES = 2'h2;

  // clock source choice
  typedef enum logic {
    TSP_SRC_TIMER   = 1'b0,
    TSP_SRC_COUNTER = 1'b1
  } tsp_src_t;

endpackage

// ---- rtl/tsp_prescaler.sv ----
`timescale 1ns/100ps
module tsp_prescaler
  import tsp_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // control
  input  wire logic                  clear_i,
  input  wire logic                  tick_i,
  input  wire logic                  to_watchdog_i,
  input  wire logic [TSP_RATE_W-1:0] rate_i,
  // divided tick
  output logic                       tick_o
);

  // parameter range guard at elaboration
  if (WIDTH < 8 || WIDTH > 16) begin : g_bad_width
    $error("tsp_prescaler: WIDTH must be 8 to 16");
  end

  logic [WIDTH-1:0] cnt_reg;
  logic [3:0]       shift;
  logic [WIDTH-1:0] mask;

  // timer ratio 2^(rate+1), watchdog ratio 2^rate
  assign shift = to_watchdog_i ? {1'b0, rate_i} : ({1'b0, rate_i} + 4'h1);
  assign mask  = WIDTH'((17'h1 << shift) - 17'h1);
  assign tick_o = tick_i && ((cnt_reg & mask) == mask);

  // hidden count, cleared on request
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      cnt_reg <= '0;
    end else if (tick_i) begin
      cnt_reg <= cnt_reg + WIDTH'(1);
    end
  end

endmodule

// ---- rtl/tsp_timer.sv ----
// Implementation choices: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
// Function
// - timer mode counts every instruction cycle
// - no increment two cycles after count write
// - counter mode counts external input edges
// - edge select picks external counting edge
// - one selects falling, zero selects rising
// - external input synchronised before edge detect
// - one prescaler, timer or watchdog, assignment bit
// - timer ratios 1:2 up to 1:256
// - watchdog assignment gives timer undivided rate
// - prescaler hidden; count write clears it when assigned to timer
// - clear watchdog clears watchdog, and prescaler when assigned to it
// - wrap from maximum sets overflow flag
// - overflow flag stays until software clears
// - interrupt only when flag and enable
// - sleep freezes the counter
module tsp_timer
  import tsp_pkg::*;
#(
  parameter int PRESCALE_WIDTH = 8
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // external count pin
  input  wire logic        ext_count_input_i,
  // watchdog side
  input  wire logic        wdt_tick_i,
  output logic             wdt_tick_o,
  output logic             wdt_clear_o,
  // interrupt
  output logic             irq_o
);

  // parameter range guard at elaboration
  if (PRESCALE_WIDTH != 8) begin : g_bad_width
    $error("tsp_timer: PRESCALE_WIDTH must be 8");
  end

  // address match helper
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a[7:2] == off[7:2]);
  endfunction

  // bus state
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic        bus_req;
  logic        bus_wr;
  logic        lane0;

  // programmable state
  logic [7:0]  timer_count_reg;
  logic        clock_source_select;
  logic        source_edge_select;
  logic        prescaler_assign;
  logic [2:0]  prescale_rate_field;
  logic        overflow_flag;
  logic        overflow_irq_enable;
  logic        sleep_reg;
  logic        clrw_reg;

  // datapath
  logic [1:0]  inhibit_reg;
  logic [1:0]  inhibit_next;
  logic        sync1_reg;
  logic        sync2_reg;
  logic        prev_reg;
  logic        ext_edge;
  logic        src_tick;
  logic        pre_in;
  logic        pre_out;
  logic        pre_clear;
  logic        count_tick;
  logic        count_inc;
  logic        wrap;
  logic        wr_count;
  logic        wr_config;
  logic        wr_status;
  logic        wr_mask;
  logic        wr_ctrl;
  tsp_src_t    src_mode;

  // bus request decode
  assign bus_req = cyc_i && stb_i;
  assign bus_wr  = bus_req && we_i && ack_reg;
  assign lane0   = sel_i[0];
  assign ack_o   = ack_reg;
  assign dat_o   = dat_reg;

  // per-register write strobes, taken at the acked edge
  assign wr_count  = bus_wr && lane0 && addr_hit(adr_i, TSP_OFF_COUNT);
  assign wr_config = bus_wr && lane0 && addr_hit(adr_i, TSP_OFF_CONFIG);
  assign wr_status = bus_wr && lane0 && addr_hit(adr_i, TSP_OFF_STATUS);
  assign wr_mask   = bus_wr && lane0 && addr_hit(adr_i, TSP_OFF_MASK);
  assign wr_ctrl   = bus_wr && lane0 && addr_hit(adr_i, TSP_OFF_CTRL);

  // one-wait-state acknowledge, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req && !ack_reg;
    end
  end

  // read data captured while the request waits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (bus_req && !ack_reg) begin
      if (addr_hit(adr_i, TSP_OFF_COUNT)) begin
        dat_reg <= {24'h00_0000, timer_count_reg};
      end else if (addr_hit(adr_i, TSP_OFF_CONFIG)) begin
        dat_reg <= {26'h0, clock_source_select, source_edge_select,
                    prescaler_assign, prescale_rate_field};
      end else if (addr_hit(adr_i, TSP_OFF_STATUS)) begin
        dat_reg <= {31'h0, overflow_flag};
      end else if (addr_hit(adr_i, TSP_OFF_MASK)) begin
        dat_reg <= {31'h0, overflow_irq_enable};
      end else if (addr_hit(adr_i, TSP_OFF_CTRL)) begin
        dat_reg <= {31'h0, sleep_reg};
      end else begin
        dat_reg <= 32'h0000_0000; // unmapped reads zero
      end
    end
  end

  // configuration bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_source_select <= TSP_CONFIG_RST[TSP_CFG_CSS_BIT];
      source_edge_select  <= TSP_CONFIG_RST[TSP_CFG_SES_BIT];
      prescaler_assign    <= TSP_CONFIG_RST[TSP_CFG_PSA_BIT];
      prescale_rate_field <= TSP_CONFIG_RST[TSP_CFG_RATE_LSB +: TSP_RATE_W];
    end else if (wr_config) begin
      clock_source_select <= dat_i[TSP_CFG_CSS_BIT];
      source_edge_select  <= dat_i[TSP_CFG_SES_BIT];
      prescaler_assign    <= dat_i[TSP_CFG_PSA_BIT];
      prescale_rate_field <= dat_i[TSP_CFG_RATE_LSB +: TSP_RATE_W];
    end
  end

  // interrupt enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_irq_enable <= TSP_MASK_RST;
    end else if (wr_mask) begin
      overflow_irq_enable <= dat_i[TSP_MSK_OVF_BIT];
    end
  end

  // sleep level and clear-watchdog strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_reg <= TSP_SLEEP_RST;
      clrw_reg  <= 1'b0;
    end else begin
      clrw_reg <= wr_ctrl && dat_i[TSP_CTL_CLRW_BIT];
      if (wr_ctrl) begin
        sleep_reg <= dat_i[TSP_CTL_SLP_BIT];
      end
    end
  end

  // two-stage synchroniser on the pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= ext_count_input_i;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // selected edge of the synchronised pin
  assign ext_edge = source_edge_select ? (prev_reg && !sync2_reg)
                                       : (!prev_reg && sync2_reg);

  // increment source, frozen in sleep
  assign src_mode = tsp_src_t'(clock_source_select);
  always_comb begin
    case (src_mode)
      TSP_SRC_TIMER:   src_tick = !sleep_reg;
      TSP_SRC_COUNTER: src_tick = ext_edge && !sleep_reg;
      default:         src_tick = 1'b0;
    endcase
  end

  // prescaler feed and clearing
  assign pre_in    = prescaler_assign ? wdt_tick_i : src_tick;
  assign pre_clear = (wr_count && !prescaler_assign)
                  || (clrw_reg && prescaler_assign);

  tsp_prescaler #(
    .WIDTH         (PRESCALE_WIDTH)
  ) u_prescaler (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .clear_i       (pre_clear),
    .tick_i        (pre_in),
    .to_watchdog_i (prescaler_assign),
    .rate_i        (prescale_rate_field),
    .tick_o        (pre_out)
  );

  // watchdog side outputs
  assign wdt_tick_o  = prescaler_assign && pre_out;
  assign wdt_clear_o = clrw_reg;

  // timer bypasses prescaler when watchdog owns it
  assign count_tick = prescaler_assign ? src_tick : pre_out;
  assign count_inc  = count_tick && (inhibit_reg == 2'h0) && !wr_count;
  assign wrap       = count_inc && (timer_count_reg == 8'hff);

  // post-write hold-off counter
  always_comb begin
    inhibit_next = inhibit_reg;
    if (wr_count) begin
      inhibit_next = TSP_INHIBIT_CYCLES;
    end else if (inhibit_reg != 2'h0) begin
      inhibit_next = inhibit_reg - 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inhibit_reg <= 2'h0;
    end else begin
      inhibit_reg <= inhibit_next;
    end
  end

  // count register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_count_reg <= TSP_COUNT_RST;
    end else if (wr_count) begin
      timer_count_reg <= dat_i[7:0];
    end else if (count_inc) begin
      timer_count_reg <= timer_count_reg + 8'h01;
    end
  end

  // sticky overflow flag, set beats write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_flag <= TSP_FLAG_RST;
    end else if (wrap) begin
      overflow_flag <= 1'b1;
    end else if (wr_status && dat_i[TSP_STS_OVF_BIT]) begin
      overflow_flag <= 1'b0;
    end
  end

  // level interrupt
  assign irq_o = overflow_flag && overflow_irq_enable;

endmodule

// ---- dv/tsp_timer_properties.sv ----
`timescale 1ns/100ps
module tsp_timer_chk
  import tsp_pkg::*;
(
  // watched ports
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        wdt_clear_o,
  input wire logic        irq_o
);
  // single clock domain
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // acked write that sets the clear-watchdog bit
  logic clrw_wr;
  assign clrw_wr = ack_o && we_i && sel_i[0] && (adr_i == TSP_OFF_CTRL)
                && dat_i[TSP_CTL_CLRW_BIT];
  // bus phases
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_clrw;
    clrw_wr;
  endsequence
  sequence s_rd;
    ack_o && !we_i;
  endsequence
  AST_ACK_WAIT: assert property (s_req |=> ack_o)
    else $error("ack late");
  AST_ACK_ONE: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  AST_CLRW_PULSE: assert property (s_clrw |=> wdt_clear_o ##1 !wdt_clear_o)
    else $error("watchdog clear pulse wrong");
  AST_CLRW_CAUSE: assert property ($rose(wdt_clear_o) |-> $past(clrw_wr))
    else $error("watchdog clear without write");
  AST_IRQ_HOLD: assert property ($fell(irq_o) |-> $past(ack_o && we_i) || $past(rst_i))
    else $error("irq dropped by itself");
  AST_UNMAP_RD: assert property (s_rd ##0 (adr_i > 8'h13) |-> dat_o == '0)
    else $error("unmapped read not zero");
  AST_CTRL_RD: assert property (s_rd ##0 (adr_i == TSP_OFF_CTRL) |-> !dat_o[TSP_CTL_CLRW_BIT])
    else $error("clear bit reads one");
  AST_RD_HIGH: assert property (s_rd |-> dat_o[31:8] == '0)
    else $error("upper read bits set");
endmodule

bind tsp_timer tsp_timer_chk i_tsp_timer_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .wdt_clear_o(wdt_clear_o), .irq_o(irq_o)
);

// ---- dv/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  // bench signals
  logic        clk = '0, rst = '1, cyc = '0, stb = '0, we = '0, ext = '0, wtick = '0;
  logic [7:0]  adr = '0;
  logic [3:0]  sel = '0, lanes = 4'h1;
  logic [31:0] wdat = '0, rdat;
  logic        ack, irq, wto, wclr;
  int          n_errors = 0, num_checks = 0, nclr = 0;
  // design under test
  tsp_timer i_tsp_timer (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .ext_count_input_i(ext),
    .wdt_tick_i(wtick), .wdt_tick_o(wto), .wdt_clear_o(wclr), .irq_o(irq)
  );
  // clock and clear-watchdog pulse count
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (wclr !== 1'b0) nclr <= nclr + 1;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // one classic bus cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= lanes;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    wb(1'b0, a, '0, q);
    chk(nm, e, q);
  endtask
  // count rate over a window of eight periods
  task automatic t_rate(input logic [7:0] c, input int p);
    logic [31:0] a, b;
    wr(8'h04, c);
    wb(1'b0, 8'h00, '0, a);
    repeat (8 * p - 3) @(posedge clk);
    wb(1'b0, 8'h00, '0, b);
    chk("rate", 32'h8, (b - a) & 32'hff);
  endtask
  // watchdog tick division
  task automatic t_wdt(input logic [7:0] c, input int e);
    int n = 0;
    wr(8'h04, c);
    wtick <= 1'b1;
    repeat (64) begin
      @(posedge clk);
      if (wto !== 1'b0) n++;
    end
    wtick <= 1'b0;
    chk("wdt ticks", e, n);
  endtask
  // prescaler handover both ways by the software sequences
  task automatic t_switch;
    wr(8'h10, 2);
    wr(8'h00, 0);
    wr(8'h04, 8'h0f);
    wr(8'h10, 2);
    wr(8'h04, 8'h0a);
    rd(8'h04, 32'h0a, "to watchdog");
    wr(8'h10, 2);
    wr(8'h04, 8'h03);
    rd(8'h04, 32'h03, "to timer");
    chk("clear pulses", 3, nclr);
  endtask
  // pin edges in counter mode
  task automatic t_ext(input logic s, input logic [31:0] e);
    ext <= 1'b0;
    repeat (8) @(posedge clk);
    wr(8'h04, {2'h0, 1'b1, s, 4'h8});
    wr(8'h00, '0);
    for (int i = 0; i < 7; i++) begin
      ext <= ~i[0];
      repeat (6) @(posedge clk);
    end
    rd(8'h00, e, "edges");
  endtask
  // overflow flag and interrupt
  task automatic t_ovf;
    wr(8'h04, 8'h08);
    wr(8'h0c, 1);
    wr(8'h00, 8'hfd);
    repeat (8) @(posedge clk);
    chk("irq", 1, irq);
    rd(8'h08, 1, "flag");
    repeat (20) @(posedge clk);
    chk("irq held", 1, irq);
    wr(8'h08, 1);
    chk("irq cleared", 0, irq);
    wr(8'h0c, 0);
    repeat (300) @(posedge clk);
    chk("irq masked", 0, irq);
    rd(8'h08, 1, "masked flag");
    wr(8'h0c, 1);
    chk("irq unmasked", 1, irq);
    wr(8'h08, 1);
  endtask
  // sleep freezes the count
  task automatic t_sleep;
    logic [31:0] a;
    wr(8'h10, 1);
    wb(1'b0, 8'h00, '0, a);
    repeat (300) @(posedge clk);
    rd(8'h08, 0, "sleep flag");
    rd(8'h00, a, "sleep count");
    wr(8'h10, 2);
    rd(8'h10, 0, "ctrl");
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(8'h04, 32'h3f, "config reset");
    rd(8'h00, 0, "count reset");
    wr(8'h14, 32'hff);
    rd(8'h14, 0, "unmapped");
    lanes = 4'h0;
    wr(8'h0c, 1);
    lanes = 4'h1;
    rd(8'h0c, 0, "lane off");
    wr(8'h04, 8'h08);
    wr(8'h00, 8'h5a);
    rd(8'h00, 8'h5a, "inhibit");
    t_rate(8'h08, 1);
    for (int r = 0; r < 8; r++) t_rate(r[7:0], 2 << r);
    t_switch();
    t_wdt(8'h0a, 16);
    t_wdt(8'h02, 0);
    t_ext(1'b0, 4);
    t_ext(1'b1, 3);
    t_ovf();
    t_sleep();
    final_report();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report();
  end
endmodule
